// *** hdl/rpc_params.svh ***
// Notes on behaviour
// - while power_down_reset_n is low the core supply regulator is off, and it turns on once the pin is high.
// - converter and core stay in reset until the core supply has reached 1.2 V and the power-on reset has released.
// - once released, the core is reset again only by a soft reset or when the supply falls below 0.6 V, a trip point used while the pin is low.
// - writing bit 7 of soft_reset_control resets the part, which is not assured after analog supply loss.
// - bit 4 of register 0x01 picks the PLL reference, master clock input or frame clock.
// - with the frame clock as reference the PLL covers 32 kHz to 192 kHz sample rates.
// - in master clock mode bits 2:0 of register 0x01 give the ratio, codes 0 to 4 meaning 128 to 768 at 32 to 48 kHz.
// - at 96 kHz codes 0 to 4 mean 64 to 384, and at 192 kHz they mean 32 to 192.
// - bit 7 of register 0x01 reports PLL lock and can be polled.
// - the high-pass filter is first order, 1.4 Hz at 48 kHz, scaling with the sample rate.
// - the reference output is off in reset and on only once the pin is high.
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH
`define RPC_ADDR_SOFT_RESET 8'h00
`define RPC_ADDR_PLL_SETUP  8'h01
`define RPC_BIT_SRST        7
`define RPC_BIT_LOCK        7
`define RPC_BIT_CLKSEL      4
`define RPC_BIT_PLL_EN      3
`define RPC_RATIO_HI        2
`define RPC_SOFT_RESET_RST  8'h00
`define RPC_PLL_SETUP_RST   8'h09
`define RPC_RATIO_MAX       3'h4
`define RPC_LOCK_TIME_US    50
`define RPC_CLK_MHZ         200
`define RPC_LOCK_CYC        (`RPC_LOCK_TIME_US * `RPC_CLK_MHZ)
`define RPC_SRST_CYC        8
`define RPC_HPF_ORDER       1
`define RPC_HPF_CUTOFF_MHZ  1400
`define RPC_HPF_REF_HZ      48000
`endif

// *** hdl/rpc_pkg.sv ***
package rpc_pkg;
  typedef enum logic [2:0] {
    RPC_OFF   = 3'b001,
    RPC_RAMP  = 3'b010,
    RPC_RUN   = 3'b100
  } rpc_state_t;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rpc_req_t;
  typedef struct packed {
    logic       supply_above_hi;
    logic       supply_above_lo;
  } rpc_mon_t;
endpackage

// *** hdl/rpc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "rpc_params.svh"
module rpc_top #(
  parameter int LOCK_CYC = `RPC_LOCK_CYC
) (
  // system
  input  wire logic             mclk,
  input  wire logic             rst,
  // pins and supply monitor
  input  wire logic             power_down_reset_n,
  input  wire rpc_pkg::rpc_mon_t mon,
  input  wire logic             ref_clock_active,
  // control port register access
  input  wire rpc_pkg::rpc_req_t req,
  output logic [7:0]            rdata,
  // analog and core control
  output logic                  regulator_en,
  output logic                  vref_en,
  output logic                  core_reset,
  output logic                  pll_enable,
  output logic                  pll_ref_is_frame,
  output logic [2:0]            mclk_ratio_code
);
  import rpc_pkg::*;

  // ----------------------------------------
  // power-on reset
  // ----------------------------------------
  rpc_state_t state_r;
  logic       srst_pend_r;
  logic [3:0] srst_cnt_r;
  logic       soft_rst;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= RPC_OFF;
    end else begin
      case (state_r)
        RPC_OFF: begin
          if (power_down_reset_n) begin
            state_r <= RPC_RAMP;
          end
        end
        RPC_RAMP: begin
          if (!power_down_reset_n && !mon.supply_above_lo) begin
            state_r <= RPC_OFF;
          end else if (power_down_reset_n && mon.supply_above_hi) begin
            state_r <= RPC_RUN;
          end
        end
        RPC_RUN: begin
          // hysteresis: a short dip with the pin high cannot reset the core
          if (!power_down_reset_n && !mon.supply_above_lo) begin
            state_r <= RPC_OFF;
          end
        end
        default: state_r <= RPC_OFF;
      endcase
    end
  end

  assign regulator_en = power_down_reset_n;
  assign vref_en      = power_down_reset_n && !rst;
  assign core_reset   = (state_r != RPC_RUN) || soft_rst;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic       srst_bit_r;
  logic [7:0] pll_setup_r;
  logic       cfg_write;
  logic       srst_write;

  assign cfg_write  = req.wr && (req.addr == `RPC_ADDR_PLL_SETUP);
  assign srst_write = req.wr && (req.addr == `RPC_ADDR_SOFT_RESET) && req.wdata[`RPC_BIT_SRST];

  // soft reset bit self-clears when its pulse ends
  always_ff @(posedge mclk) begin
    if (rst || state_r != RPC_RUN) begin
      srst_pend_r <= 1'b0;
      srst_cnt_r  <= 4'h0;
    end else if (srst_write) begin
      srst_pend_r <= 1'b1;
      srst_cnt_r  <= 4'(`RPC_SRST_CYC);
    end else if (srst_cnt_r != 4'h0) begin
      srst_cnt_r <= srst_cnt_r - 4'h1;
    end else begin
      srst_pend_r <= 1'b0;
    end
  end
  assign soft_rst   = srst_pend_r;
  assign srst_bit_r = srst_pend_r;

  always_ff @(posedge mclk) begin
    if (rst || core_reset) begin
      pll_setup_r <= `RPC_PLL_SETUP_RST;
    end else if (cfg_write) begin
      pll_setup_r <= {1'b0, req.wdata[6:0]};
    end
  end

  assign pll_enable       = pll_setup_r[`RPC_BIT_PLL_EN];
  assign pll_ref_is_frame = pll_setup_r[`RPC_BIT_CLKSEL];
  // ratio meaning by sample rate lives in the analog PLL; codes above 4 are not valid
  assign mclk_ratio_code  = pll_setup_r[`RPC_RATIO_HI:0];

  // ----------------------------------------
  // lock tracking
  // ----------------------------------------
  logic [$clog2(LOCK_CYC+1)-1:0] lock_cnt_r;
  logic                          lock_r;
  logic                          lock_stop;
  logic                          lock_full;

  // any setup write restarts the count, so a reprogrammed loop never shows a stale lock
  assign lock_stop = rst || core_reset || !pll_enable || cfg_write || !ref_clock_active;
  assign lock_full = (lock_cnt_r == ($bits(lock_cnt_r))'(LOCK_CYC));

  always_ff @(posedge mclk) begin
    if (lock_stop) begin
      lock_cnt_r <= '0;
      lock_r     <= 1'b0;
    end else if (lock_full) begin
      lock_r <= 1'b1;
    end else begin
      lock_cnt_r <= lock_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd && req.addr == `RPC_ADDR_SOFT_RESET) begin
      rdata <= {srst_bit_r, 7'h00};
    end else if (req.rd && req.addr == `RPC_ADDR_PLL_SETUP) begin
      rdata <= {lock_r, pll_setup_r[6:0]};
    end else if (req.rd) begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // high-pass corner
  // ----------------------------------------
  // the filter sits in the audio path outside this block; only its scaling
  // law is kept here, so the corner tracks whatever sample rate is in use
  localparam int HPF_ORDER      = `RPC_HPF_ORDER;
  localparam int HPF_CUTOFF_MHZ = `RPC_HPF_CUTOFF_MHZ;
  localparam int HPF_REF_HZ     = `RPC_HPF_REF_HZ;

  // corner in millihertz for a sample rate in hertz, in direct proportion
  function automatic longint hpf_corner_mhz(input longint rate_hz);
    return (rate_hz * HPF_CUTOFF_MHZ) / HPF_REF_HZ;
  endfunction

  // ----------------------------------------
  // checks: power and reset
  // ----------------------------------------
  regulator_follows_a: assert property (@(posedge mclk) regulator_en == power_down_reset_n)
    else $error("regulator not following pin");
  vref_off_a: assert property (@(posedge mclk) !power_down_reset_n |-> !vref_en)
    else $error("vref on in reset");
  vref_on_a: assert property (@(posedge mclk) (power_down_reset_n && !rst) |-> vref_en)
    else $error("vref off with pin high");
  state_onehot_a: assert property (@(posedge mclk) disable iff (rst)
    $onehot(state_r))
    else $error("power state not one-hot");
  ramp_entry_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_OFF && power_down_reset_n) |=> state_r == RPC_RAMP)
    else $error("pin high did not start ramp");
  off_holds_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_OFF && !power_down_reset_n) |=> state_r == RPC_OFF)
    else $error("core woke with pin low");
  core_held_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r != RPC_RUN) |-> core_reset)
    else $error("core left reset early");
  run_needs_supply_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RAMP && !mon.supply_above_hi) |=> state_r != RPC_RUN)
    else $error("core released below upper trip");
  core_release_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RAMP && power_down_reset_n && mon.supply_above_hi) |=> state_r == RPC_RUN)
    else $error("core not released at upper trip");
  no_glitch_reset_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RUN && power_down_reset_n) |=> state_r == RPC_RUN)
    else $error("core reset while pin high");
  lo_trip_reset_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r != RPC_OFF && !power_down_reset_n && !mon.supply_above_lo) |=> state_r == RPC_OFF)
    else $error("core not reset below lower trip");

  // ----------------------------------------
  // checks: soft reset
  // ----------------------------------------
  soft_reset_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RUN && srst_write) |=> core_reset[*8])
    else $error("soft reset did not hold core");
  srst_load_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RUN && srst_write) |=> (srst_pend_r && srst_cnt_r == 4'(`RPC_SRST_CYC)))
    else $error("soft reset pulse not loaded");
  srst_count_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RUN && !srst_write && srst_cnt_r != 4'h0) |=> srst_cnt_r == $past(srst_cnt_r) - 4'h1)
    else $error("soft reset counter skipped");
  srst_end_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == RPC_RUN && !srst_write && srst_pend_r && srst_cnt_r == 4'h0) |=> !srst_pend_r)
    else $error("soft reset pulse did not end");
  srst_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !srst_pend_r |-> srst_cnt_r == 4'h0)
    else $error("soft reset counter running while idle");
  srst_drop_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r != RPC_RUN) |=> !srst_pend_r)
    else $error("soft reset pending through power reset");

  // ----------------------------------------
  // checks: pll setup
  // ----------------------------------------
  ref_select_a: assert property (@(posedge mclk) disable iff (rst)
    (cfg_write && !core_reset) |=> pll_ref_is_frame == $past(req.wdata[`RPC_BIT_CLKSEL]))
    else $error("reference select not stored");
  ratio_stored_a: assert property (@(posedge mclk) disable iff (rst)
    (cfg_write && !core_reset) |=> mclk_ratio_code == $past(req.wdata[`RPC_RATIO_HI:0]))
    else $error("ratio not stored");
  setup_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (!cfg_write && !core_reset) |=> $stable(pll_setup_r))
    else $error("pll setup changed without a write");
  setup_default_a: assert property (@(posedge mclk) disable iff (rst)
    core_reset |=> pll_setup_r == `RPC_PLL_SETUP_RST)
    else $error("pll setup not defaulted in reset");
  lock_bit_ro_a: assert property (@(posedge mclk) disable iff (rst)
    pll_setup_r[`RPC_BIT_LOCK] == 1'b0)
    else $error("lock bit stored from a write");

  // ----------------------------------------
  // checks: lock
  // ----------------------------------------
  lock_clear_a: assert property (@(posedge mclk) disable iff (rst)
    (core_reset || !pll_enable || cfg_write) |=> !lock_r)
    else $error("lock shown while unlockable");
  lock_noref_a: assert property (@(posedge mclk) disable iff (rst)
    !ref_clock_active |=> !lock_r)
    else $error("lock shown without reference");
  lock_count_a: assert property (@(posedge mclk) disable iff (rst)
    (!lock_stop && !lock_full) |=> lock_cnt_r == $past(lock_cnt_r) + 1'b1)
    else $error("lock counter stalled");
  lock_set_a: assert property (@(posedge mclk) disable iff (rst)
    (!lock_stop && lock_full) |=> lock_r)
    else $error("lock not reported after settle time");
  lock_late_a: assert property (@(posedge mclk) disable iff (rst)
    $rose(lock_r) |-> $past(lock_full))
    else $error("lock reported before settle time");

  // ----------------------------------------
  // checks: read back
  // ----------------------------------------
  read_lock_a: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && req.addr == `RPC_ADDR_PLL_SETUP) |=> (rdata[7] == $past(lock_r) && rdata[6:0] == $past(pll_setup_r[6:0])))
    else $error("pll setup read wrong");
  read_srst_a: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && req.addr == `RPC_ADDR_SOFT_RESET) |=> (rdata[7] == $past(srst_pend_r) && rdata[6:0] == 7'h00))
    else $error("soft reset read wrong");
  read_unmapped_a: assert property (@(posedge mclk) disable iff (rst)
    (req.rd && req.addr != `RPC_ADDR_SOFT_RESET && req.addr != `RPC_ADDR_PLL_SETUP) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (@(posedge mclk) disable iff (rst)
    !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");

  c_run: cover property (@(posedge mclk) disable iff (rst) state_r == RPC_RAMP ##1 state_r == RPC_RUN);
  c_lock: cover property (@(posedge mclk) disable iff (rst) $rose(lock_r));
  c_srst: cover property (@(posedge mclk) disable iff (rst) $rose(srst_pend_r));
  c_frame_lock: cover property (@(posedge mclk) disable iff (rst) pll_ref_is_frame && $rose(lock_r));
  c_dip_ride: cover property (@(posedge mclk) disable iff (rst)
    state_r == RPC_RUN && !mon.supply_above_hi && !power_down_reset_n);
endmodule // rpc_top
`default_nettype wire

// *** test/rpc_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module rpc_host (
  // clock and answer
  input  wire logic       mclk,
  input  wire logic [7:0] rdata,
  // request
  output var rpc_pkg::rpc_req_t req
);
  import rpc_pkg::*;
  initial req = '0;
  // released lines show inverted data, never the old value
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk) req <= '{1'b1, 1'b0, a, v};
    @(posedge mclk) req <= '{1'b0, 1'b0, ~a, ~v};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) req <= '{1'b0, 1'b0, ~a, 8'hff};
    @(posedge mclk) #1 v = rdata;
  endtask
endmodule // rpc_host
`default_nettype wire

// *** test/rpc_top_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module rpc_top_bench;
  import rpc_pkg::*;
  localparam int LC = 20;
  logic mclk, rst, pin, ref_act, reg_en, vref_en, core_rst, pll_en, ref_fr;
  logic [2:0] ratio;
  logic [7:0] rdata, d;
  rpc_mon_t mon;
  rpc_req_t req;
  int miscompares, compares, cyc;
  rpc_top #(.LOCK_CYC(LC)) u_rpc_top (.mclk(mclk), .rst(rst), .power_down_reset_n(pin),
    .mon(mon), .ref_clock_active(ref_act), .req(req), .rdata(rdata), .regulator_en(reg_en),
    .vref_en(vref_en), .core_reset(core_rst), .pll_enable(pll_en), .pll_ref_is_frame(ref_fr),
    .mclk_ratio_code(ratio));
  rpc_host u_rpc_host (.mclk(mclk), .rdata(rdata), .req(req));
  // ----
  // checks
  // ----
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize;
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_down;
    wt(1);
    chk("regulator_en", 8'h00, 8'(reg_en));
    chk("vref_en", 8'h00, 8'(vref_en));
    u_rpc_host.wr(8'h01, 8'h18);
    wt(0);
    chk("core_reset", 8'h01, 8'(core_rst));
    chk("ignored write", 8'h00, 8'(ref_fr));
  endtask
  task automatic t_por;
    @(posedge mclk) pin <= 1'b1;
    wt(2);
    chk("regulator_en", 8'h01, 8'(reg_en));
    chk("vref_en", 8'h01, 8'(vref_en));
    chk("core_reset low supply", 8'h01, 8'(core_rst));
    @(posedge mclk) mon <= '{1'b1, 1'b1};
    wt(4); // charge-up wait before access
    chk("core_reset", 8'h00, 8'(core_rst));
    u_rpc_host.rd(8'h01, d);
    chk("pll_setup", 8'h09, d);
    u_rpc_host.rd(8'h05, d);
    chk("unmapped", 8'h00, d);
  endtask
  task automatic t_hyst;
    @(posedge mclk) mon <= '{1'b0, 1'b1};
    wt(3);
    chk("glitch", 8'h00, 8'(core_rst));
    @(posedge mclk) pin <= 1'b0; // held low until below lower trip
    wt(3);
    chk("above lo", 8'h00, 8'(core_rst));
    @(posedge mclk) mon <= '{1'b0, 1'b0};
    wt(2);
    chk("below lo", 8'h01, 8'(core_rst));
    @(posedge mclk) pin <= 1'b1;
    @(posedge mclk) mon <= '{1'b1, 1'b1};
    wt(3);
    chk("re-released", 8'h00, 8'(core_rst));
  endtask
  task automatic t_pll;
    for (int i = 0; i < 5; i++) begin
      u_rpc_host.wr(8'h01, 8'(i));
      wt(0);
      chk("ratio", 8'(i), 8'(ratio));
      chk("pll_enable", 8'h00, 8'(pll_en));
    end
    u_rpc_host.wr(8'h01, 8'h18);
    wt(0);
    chk("ref_frame", 8'h01, 8'(ref_fr));
    @(posedge mclk) ref_act <= 1'b1; // frame clock from an external master
    wt(LC + 6);
    u_rpc_host.rd(8'h01, d);
    chk("locked", 8'h98, d);
    u_rpc_host.wr(8'h01, 8'h10);
    u_rpc_host.rd(8'h01, d);
    chk("lock off", 8'h10, d);
  endtask
  task automatic t_srst;
    u_rpc_host.wr(8'h00, 8'h80);
    wt(0);
    chk("soft reset", 8'h01, 8'(core_rst));
    u_rpc_host.rd(8'h00, d);
    chk("soft reset bit", 8'h80, d);
    wt(12);
    chk("soft reset end", 8'h00, 8'(core_rst));
    u_rpc_host.rd(8'h01, d);
    chk("pll_setup reset", 8'h09, d);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    mon = '0;
    ref_act = 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_down();
    t_por();
    t_hyst();
    t_pll();
    t_srst();
    summarize();
  end
endmodule // rpc_top_bench
`default_nettype wire
